// ==== hdl/audio_serial_consts.svh ====
// Register indices, field positions and reset values of the audio serial unit
`ifndef AUDIO_SERIAL_CONSTS_SVH
`define AUDIO_SERIAL_CONSTS_SVH
// Register indices; byte address is four times the index
`define IDX_MAIN      4'h0
`define IDX_DATA0     4'h1
`define IDX_DATA3     4'h4
`define IDX_INTCTL    4'h6
`define IDX_FSTAT     4'h7
`define IDX_PSTAT     4'h8
`define IDX_PART0     4'h9
`define IDX_PART3     4'hC
// Main control fields
`define MAIN_EN_BIT   0
`define MAIN_MST_LO   8
`define MAIN_FMT_LO   12
`define MAIN_DIR_LO   20
`define MAIN_PEN_LO   26
// Interrupt control fields
`define INT_ID_LO     0
`define INT_EN_LO     8
// Partition control fields
`define PART_ST_LO    0
`define PART_END_LO   4
`define PART_WM_LO    8
`define PART_WP_LO    16
`define PART_RP_LO    24
// Per-port status nibble positions
`define FS_FE         0
`define FS_FH         1
`define FS_FF         2
`define FS_FI         3
`define PS_IL         0
`define PS_IH         1
`define PS_OL         2
`define PS_OH         3
// Serial framing
`define CH_BITS       6'h10
`define CH_LAST       6'h0F
`define CNT_MAX       6'h3F
`define IDX_LAST_L    5'h0F
`define IDX_LAST_R    5'h1F
`define LOW3_ZERO     3'h0
`define LOW3_ONE      3'h7
`define WORD_ZERO     32'h0000_0000
`endif

// ==== hdl/audio_serial_pkg.sv ====
// Types shared by the audio serial unit
package audio_serial_pkg;
  // Programmed partition layout
  typedef struct packed {
    logic [7:0] wm;
    logic [3:0] end_hi;
    logic [3:0] st_hi;
  } part_cfg_t;
  // Per-partition flags
  typedef struct packed {
    logic fi;
    logic ff;
    logic fh;
    logic fe;
  } part_flags_t;
  // Slot decode result
  typedef struct packed {
    logic       valid;
    logic [4:0] idx;
  } slot_t;
endpackage

// ==== hdl/audio_serial_fifo_port_unit.sv ====
// Four-port audio serial unit with partitioned shared FIFO and register port
`timescale 1ns/100ps
`include "audio_serial_consts.svh"
module audio_serial_fifo_port_unit
  import audio_serial_pkg::*;
#(
  parameter int NPORT = 4,
  parameter int DEPTH = 128
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Register port
  input  wire logic [5:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr_stb,
  input  wire logic             rd_stb,
  output logic      [31:0]      rdata_r,
  output logic                  target_ready_r,
  // Serial clock shared by all ports
  input  wire logic             sck_in,
  // Word select pins
  input  wire logic [NPORT-1:0] ws_in,
  output logic      [NPORT-1:0] ws_out_r,
  output logic      [NPORT-1:0] ws_oe_b_r,
  // Serial data pins
  input  wire logic [NPORT-1:0] serial_data_input,
  output logic      [NPORT-1:0] serial_data_output_r,
  output logic      [NPORT-1:0] sd_oe_b_r,
  // Interrupt pulses
  output logic                  int_rd_r,
  output logic                  int_wr_r
);
  // Control registers
  logic [31:0]      main_r;
  logic [NPORT-1:0] int_en_r;
  logic [NPORT-1:0] int_id_r;
  part_cfg_t        cfg_r [NPORT];
  logic             en;
  logic [NPORT-1:0] mst;
  logic [NPORT-1:0] fmt_j;
  logic [NPORT-1:0] dir_in;
  logic [NPORT-1:0] pen;
  assign en     = main_r[`MAIN_EN_BIT];
  assign mst    = main_r[`MAIN_MST_LO +: NPORT];
  assign fmt_j  = main_r[`MAIN_FMT_LO +: NPORT];
  assign dir_in = main_r[`MAIN_DIR_LO +: NPORT];
  assign pen    = main_r[`MAIN_PEN_LO +: NPORT];

  // Synchronisers; first stages read only by second stages
  logic             sck_s1, sck_s2, sck_s3;
  logic [NPORT-1:0] ws_s1, ws_s2;
  logic [NPORT-1:0] sd_s1, sd_s2;
  logic             sck_rise, sck_fall;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      ws_s1  <= '0;
      ws_s2  <= '0;
      sd_s1  <= '0;
      sd_s2  <= '0;
    end else begin
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      ws_s1  <= ws_in;
      ws_s2  <= ws_s1;
      sd_s1  <= serial_data_input;
      sd_s2  <= sd_s1;
    end
  end
  assign sck_rise = sck_s2 & ~sck_s3;
  assign sck_fall = ~sck_s2 & sck_s3;

  // Map a channel slot count to a word bit index
  function automatic slot_t slot_map(input logic [5:0] cnt, input logic ch, input logic just, input logic tail);
    slot_t      s;
    logic [5:0] c1;
    s  = '0;
    c1 = cnt - 6'h01;
    if (just) begin
      s.valid = (cnt < `CH_BITS);
      s.idx   = {ch, cnt[3:0]};
    end else if (cnt == 6'h00) begin
      // Standard framing: first slot carries previous channel LSB
      s.valid = tail;
      s.idx   = {~ch, 4'hF};
    end else begin
      s.valid = (cnt <= `CH_BITS);
      s.idx   = {ch, c1[3:0]};
    end
    return s;
  endfunction

  // Bit counters per port
  logic [5:0]       bit_clock_counter [NPORT];
  logic [NPORT-1:0] ch_r;
  logic [NPORT-1:0] len16_r;
  logic [5:0]       cnt_nxt [NPORT];
  logic [NPORT-1:0] ch_nxt;
  logic [NPORT-1:0] len16_nxt;
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      cnt_nxt[p]   = bit_clock_counter[p];
      ch_nxt[p]    = ch_r[p];
      len16_nxt[p] = len16_r[p];
      if (mst[p]) begin
        if (bit_clock_counter[p] == `CH_LAST) begin
          cnt_nxt[p]   = 6'h00;
          ch_nxt[p]    = ~ch_r[p];
          len16_nxt[p] = 1'b1;
        end else begin
          cnt_nxt[p] = bit_clock_counter[p] + 6'h01;
        end
      end else if (ws_s2[p] != ch_r[p]) begin
        cnt_nxt[p]   = 6'h00;
        ch_nxt[p]    = ws_s2[p];
        len16_nxt[p] = (bit_clock_counter[p] == `CH_LAST);
      end else if (bit_clock_counter[p] != `CNT_MAX) begin
        cnt_nxt[p] = bit_clock_counter[p] + 6'h01;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NPORT; p++) bit_clock_counter[p] <= 6'h00;
      ch_r     <= '0;
      len16_r  <= '0;
      ws_out_r <= '0;
    end else if (!en) begin
      for (int p = 0; p < NPORT; p++) bit_clock_counter[p] <= 6'h00;
      ch_r     <= '0;
      len16_r  <= '0;
      ws_out_r <= '0;
    end else begin
      if (sck_rise) begin
        for (int p = 0; p < NPORT; p++) bit_clock_counter[p] <= cnt_nxt[p];
        ch_r    <= ch_nxt;
        len16_r <= len16_nxt;
      end
      // Word select moves on the trailing edge one slot ahead, so in standard framing a receiver sees it change
      // together with the last bit of the previous channel; a port that stops mastering lets go at once
      if (sck_fall) begin
        for (int p = 0; p < NPORT; p++)
          ws_out_r[p] <= mst[p] & ((bit_clock_counter[p] == `CH_LAST) ? ~ch_r[p] : ch_r[p]);
      end else begin
        ws_out_r <= ws_out_r & mst;
      end
    end
  end

  // Pin direction controls, low enable means driving
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ws_oe_b_r <= '1;
      sd_oe_b_r <= '1;
    end else begin
      ws_oe_b_r <= ~(mst & {NPORT{en}});
      sd_oe_b_r <= ~(~dir_in & {NPORT{en}});
    end
  end

  // Holding registers and half-valid flags
  logic [31:0]      in_sh   [NPORT];
  logic [31:0]      in_hold [NPORT];
  logic [31:0]      out_hold[NPORT];
  logic [31:0]      out_sh  [NPORT];
  logic [NPORT-1:0] in_upper_half_valid, in_lower_half_valid;
  logic [NPORT-1:0] out_upper_half_valid, out_lower_half_valid;
  logic [NPORT-1:0] ser_done;
  logic [NPORT-1:0] ser_load;
  logic [NPORT-1:0] bus_wr_data;
  logic [NPORT-1:0] bus_rd_data;
  logic [NPORT-1:0] wsel, rsel;
  logic [31:0]      mem [DEPTH];
  logic [6:0]       wptr_r [NPORT];
  logic [6:0]       rptr_r [NPORT];

  // Data-port strobes decoded per port
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      bus_wr_data[p] = wr_stb && (addr[5:2] == `IDX_DATA0 + 4'(p)) && !dir_in[p];
      bus_rd_data[p] = rd_stb && (addr[5:2] == `IDX_DATA0 + 4'(p)) && dir_in[p];
    end
  end

  // Serial input assembly and output shifting
  always_ff @(posedge clk or negedge rst_b) begin
    slot_t si;
    slot_t so;
    if (!rst_b) begin
      for (int p = 0; p < NPORT; p++) begin
        in_sh[p]  <= `WORD_ZERO;
        out_sh[p] <= `WORD_ZERO;
      end
      ser_done             <= '0;
      ser_load             <= '0;
      serial_data_output_r <= '0;
    end else begin
      ser_done <= '0;
      ser_load <= '0;
      for (int p = 0; p < NPORT; p++) begin
        si = slot_map(cnt_nxt[p], ch_nxt[p], fmt_j[p], len16_nxt[p]);
        if (mst[p] && bit_clock_counter[p] == `CH_LAST)
          so = slot_map(6'h00, ~ch_r[p], fmt_j[p], 1'b1);
        else
          so = slot_map(bit_clock_counter[p] + 6'h01, ch_r[p], fmt_j[p], len16_r[p]);
        if (!en) begin
          serial_data_output_r[p] <= 1'b0;
        end else if (sck_rise && dir_in[p] && si.valid) begin
          in_sh[p][~si.idx] <= sd_s2[p];
          ser_done[p]       <= (si.idx == `IDX_LAST_R);
        end else if (sck_fall && !dir_in[p]) begin
          // Data changes on trailing edge so the receiver samples it stable
          if (so.valid && so.idx == 5'h00) begin
            // An empty holding register gives a silent frame, never the stale previous word
            out_sh[p]               <= out_upper_half_valid[p] ? out_hold[p] : `WORD_ZERO;
            ser_load[p]             <= 1'b1;
            serial_data_output_r[p] <= out_hold[p][31] & out_upper_half_valid[p];
          end else begin
            serial_data_output_r[p] <= so.valid & out_sh[p][~so.idx];
          end
        end
      end
    end
  end

  // Input holding register: bus word for output ports, serial word for input ports
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NPORT; p++) in_hold[p] <= `WORD_ZERO;
      in_upper_half_valid <= '0;
      in_lower_half_valid <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (!en) begin
          in_upper_half_valid[p] <= 1'b0;
          in_lower_half_valid[p] <= 1'b0;
        end else if (wsel[p]) begin
          in_upper_half_valid[p] <= 1'b0;
          in_lower_half_valid[p] <= 1'b0;
        end else if (!in_upper_half_valid[p] && !in_lower_half_valid[p]) begin
          if (bus_wr_data[p]) begin
            in_hold[p]             <= wdata;
            in_upper_half_valid[p] <= 1'b1;
            in_lower_half_valid[p] <= 1'b1;
          end else if (ser_done[p] && dir_in[p]) begin
            in_hold[p]             <= in_sh[p];
            in_upper_half_valid[p] <= 1'b1;
            in_lower_half_valid[p] <= 1'b1;
          end
        end
      end
    end
  end

  // Output holding register: reloaded from FIFO, emptied by bus read or serial load
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NPORT; p++) out_hold[p] <= `WORD_ZERO;
      out_upper_half_valid <= '0;
      out_lower_half_valid <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (!en) begin
          out_upper_half_valid[p] <= 1'b0;
          out_lower_half_valid[p] <= 1'b0;
        end else if (rsel[p]) begin
          out_hold[p]             <= mem[rptr_r[p]];
          out_upper_half_valid[p] <= 1'b1;
          out_lower_half_valid[p] <= 1'b1;
        end else if (bus_rd_data[p] || ser_load[p]) begin
          out_upper_half_valid[p] <= 1'b0;
          out_lower_half_valid[p] <= 1'b0;
        end
      end
    end
  end

  // Partition flags and counters
  logic [7:0]       count_r [NPORT];
  logic [6:0]       st_addr [NPORT];
  logic [6:0]       end_addr[NPORT];
  part_flags_t      flg     [NPORT];
  logic [NPORT-1:0] fh_prev_r;
  logic [NPORT-1:0] fi_r;
  logic [NPORT-1:0] wr_req, rd_req;
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      st_addr[p]  = {cfg_r[p].st_hi, `LOW3_ZERO};
      end_addr[p] = {cfg_r[p].end_hi, `LOW3_ONE};
      flg[p].fe   = (count_r[p] == 8'h00);
      flg[p].ff   = (count_r[p] == (8'(end_addr[p]) - 8'(st_addr[p]) + 8'h01));
      // Input partitions flag above the mark, output ones at or above it
      flg[p].fh   = dir_in[p] ? (count_r[p] > cfg_r[p].wm) : (count_r[p] >= cfg_r[p].wm);
      flg[p].fi   = fi_r[p];
      wr_req[p]   = en && pen[p] && in_upper_half_valid[p] && in_lower_half_valid[p] && !flg[p].ff;
      rd_req[p]   = en && pen[p] && !out_upper_half_valid[p] && !out_lower_half_valid[p] && !flg[p].fe;
    end
  end

  // Arbiter: one write and one read per cycle, serial ports first
  always_comb begin
    wsel = '0;
    rsel = '0;
    for (int p = NPORT - 1; p >= 0; p--) begin
      if (wr_req[p] && !dir_in[p]) wsel = NPORT'(1) << p;
      if (rd_req[p] && dir_in[p])  rsel = NPORT'(1) << p;
    end
    // Later loop overrides, so the serial side wins
    for (int p = NPORT - 1; p >= 0; p--) begin
      if (wr_req[p] && dir_in[p])  wsel = NPORT'(1) << p;
      if (rd_req[p] && !dir_in[p]) rsel = NPORT'(1) << p;
    end
  end

  // Shared memory write port; read port is asynchronous
  always_ff @(posedge clk) begin
    for (int p = 0; p < NPORT; p++)
      if (wsel[p]) mem[wptr_r[p]] <= in_hold[p];
  end

  // Pointers and stored-word counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NPORT; p++) begin
        wptr_r[p]  <= 7'h00;
        rptr_r[p]  <= 7'h00;
        count_r[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (!en) begin
          wptr_r[p]  <= 7'h00;
          rptr_r[p]  <= 7'h00;
          count_r[p] <= 8'h00;
        end else begin
          if (wsel[p])
            wptr_r[p] <= (wptr_r[p] == end_addr[p]) ? st_addr[p] : wptr_r[p] + 7'h01;
          else if (wptr_r[p] < st_addr[p] || wptr_r[p] > end_addr[p])
            wptr_r[p] <= st_addr[p];
          if (rsel[p])
            rptr_r[p] <= (rptr_r[p] == end_addr[p]) ? st_addr[p] : rptr_r[p] + 7'h01;
          else if (rptr_r[p] < st_addr[p] || rptr_r[p] > end_addr[p])
            rptr_r[p] <= st_addr[p];
          if (wsel[p] && !rsel[p])
            count_r[p] <= count_r[p] + 8'h01;
          else if (rsel[p] && !wsel[p])
            count_r[p] <= count_r[p] - 8'h01;
        end
      end
    end
  end

  // Event pulses and interrupt lines
  logic [NPORT-1:0] ev_w, ev_r;
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      ev_w[p] = !dir_in[p] && fh_prev_r[p] && !flg[p].fh;
      ev_r[p] = dir_in[p] && !fh_prev_r[p] && flg[p].fh;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fh_prev_r <= '0;
      fi_r      <= '0;
      int_wr_r  <= 1'b0;
      int_rd_r  <= 1'b0;
      int_id_r  <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) fh_prev_r[p] <= flg[p].fh & en;
      fi_r     <= (ev_w | ev_r) & {NPORT{en}};
      int_wr_r <= |(ev_w & int_en_r) & en;
      int_rd_r <= |(ev_r & int_en_r) & en;
      // Read of interrupt control clears identify bits; a new event wins
      if (rd_stb && addr[5:2] == `IDX_INTCTL)
        int_id_r <= (ev_w | ev_r) & int_en_r;
      else
        int_id_r <= int_id_r | ((ev_w | ev_r) & int_en_r);
    end
  end

  // Register writes; read-only locations ignore writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      main_r   <= `WORD_ZERO;
      int_en_r <= '0;
      for (int p = 0; p < NPORT; p++) cfg_r[p] <= '0;
    end else if (wr_stb) begin
      if (addr[5:2] == `IDX_MAIN) main_r <= wdata;
      if (addr[5:2] == `IDX_INTCTL) int_en_r <= wdata[`INT_EN_LO +: NPORT];
      for (int p = 0; p < NPORT; p++)
        if (addr[5:2] == `IDX_PART0 + 4'(p)) begin
          cfg_r[p].st_hi  <= wdata[`PART_ST_LO +: 4];
          cfg_r[p].end_hi <= wdata[`PART_END_LO +: 4];
          cfg_r[p].wm     <= wdata[`PART_WM_LO +: 8];
        end
    end
  end

  // Register reads, answered in the next cycle
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = `WORD_ZERO;
    if (addr[5:2] == `IDX_MAIN) rd_mux = main_r;
    if (addr[5:2] == `IDX_INTCTL) begin
      rd_mux[`INT_EN_LO +: NPORT] = int_en_r;
      rd_mux[`INT_ID_LO +: NPORT] = int_id_r;
    end
    for (int p = 0; p < NPORT; p++) begin
      if (addr[5:2] == `IDX_DATA0 + 4'(p) && dir_in[p] && out_upper_half_valid[p])
        rd_mux = out_hold[p];
      if (addr[5:2] == `IDX_FSTAT) rd_mux[4*p +: 4] = flg[p];
      if (addr[5:2] == `IDX_PSTAT) begin
        rd_mux[4*p + `PS_IL] = in_lower_half_valid[p];
        rd_mux[4*p + `PS_IH] = in_upper_half_valid[p];
        rd_mux[4*p + `PS_OL] = out_lower_half_valid[p];
        rd_mux[4*p + `PS_OH] = out_upper_half_valid[p];
      end
      if (addr[5:2] == `IDX_PART0 + 4'(p)) begin
        rd_mux[`PART_ST_LO +: 4]  = cfg_r[p].st_hi;
        rd_mux[`PART_END_LO +: 4] = cfg_r[p].end_hi;
        rd_mux[`PART_WM_LO +: 8]  = cfg_r[p].wm;
        rd_mux[`PART_WP_LO +: 7]  = wptr_r[p];
        rd_mux[`PART_RP_LO +: 7]  = rptr_r[p];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r        <= `WORD_ZERO;
      target_ready_r <= 1'b0;
    end else begin
      rdata_r        <= rd_stb ? rd_mux : `WORD_ZERO;
      target_ready_r <= rd_stb | wr_stb;
    end
  end
endmodule

// ==== bench/audio_serial_fifo_port_unit_checker.sv ====
// Port-level assertions for the audio serial unit
`timescale 1ns/100ps
module audio_serial_fifo_port_unit_checker #(
  parameter int NPORT = 4
) (
  input wire logic             clk,
  input wire logic             rst_b,
  input wire logic [5:0]       addr,
  input wire logic [31:0]      wdata,
  input wire logic             wr_stb,
  input wire logic             rd_stb,
  input wire logic [31:0]      rdata_r,
  input wire logic             target_ready_r,
  input wire logic             sck_in,
  input wire logic [NPORT-1:0] ws_in,
  input wire logic [NPORT-1:0] ws_out_r,
  input wire logic [NPORT-1:0] ws_oe_b_r,
  input wire logic [NPORT-1:0] serial_data_input,
  input wire logic [NPORT-1:0] serial_data_output_r,
  input wire logic [NPORT-1:0] sd_oe_b_r,
  input wire logic             int_rd_r,
  input wire logic             int_wr_r
);
  logic [31:0] main_r;
  logic [3:0]  ien_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Shadows of main and interrupt control; the enable, master and direction bits feed the checks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      main_r <= 32'h0000_0000;
      ien_r  <= 4'h0;
    end else if (wr_stb) begin
      if (addr[5:2] == 4'h0) main_r <= wdata;
      if (addr[5:2] == 4'h6) ien_r <= wdata[11:8];
    end
  end
  chk_ack_follows: assert property ((wr_stb || rd_stb) |=> target_ready_r)
    else $error("no acknowledge after a strobe");
  chk_ack_cause: assert property (target_ready_r |-> $past(wr_stb || rd_stb))
    else $error("acknowledge without a strobe");
  chk_rdata_quiet: assert property (!$past(rd_stb) |-> rdata_r == 32'h0000_0000)
    else $error("read data outside its answer cycle");
  chk_ws_oe_master: assert property ($stable(main_r) [*3] |->
    ws_oe_b_r == ~(main_r[11:8] & {4{main_r[0]}})) else $error("word select drive wrong");
  chk_sd_oe_dir: assert property ($stable(main_r) [*3] |->
    sd_oe_b_r == ~(~main_r[23:20] & {4{main_r[0]}})) else $error("data drive wrong");
  chk_ws_slave_zero: assert property ((ws_out_r & ws_oe_b_r) == 4'h0)
    else $error("undriven word select not zero");
  chk_int_rd_gate: assert property (int_rd_r |-> |(ien_r & main_r[23:20]) ||
    |($past(ien_r) & $past(main_r[23:20]))) else $error("read interrupt without enabled input");
  chk_int_wr_gate: assert property (int_wr_r |-> |(ien_r & ~main_r[23:20]) ||
    |($past(ien_r) & ~$past(main_r[23:20]))) else $error("write interrupt without enabled output");
endmodule
bind audio_serial_fifo_port_unit audio_serial_fifo_port_unit_checker #(.NPORT(NPORT)) u_chk (
  .clk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb, .rdata_r, .target_ready_r, .sck_in, .ws_in,
  .ws_out_r, .ws_oe_b_r, .serial_data_input, .serial_data_output_r, .sd_oe_b_r, .int_rd_r, .int_wr_r);

// ==== bench/audio_serial_peer.sv ====
// Converter model: bit clock source, slave transmitter and frame receiver
`timescale 1ns/100ps
module audio_serial_peer (
  // Control from the bench
  input  wire logic        run,
  input  wire logic [31:0] tx_word,
  // Lines to and from the unit
  output logic             sck,
  output logic             ws_slv,
  output logic             sd_to_unit,
  input  wire logic        ws_mst,
  input  wire logic        sd_from_unit,
  // Captured frames
  output logic [31:0]      rx_word,
  output int               rx_cnt
);
  logic [4:0]  slot;
  logic [31:0] sr;
  logic        ws_prev;
  initial begin
    sck = 1'b0;
    ws_slv = 1'b0;
    sd_to_unit = 1'b0;
    slot = 5'h00;
    sr = 32'h0000_0000;
    ws_prev = 1'b0;
    rx_word = 32'h0000_0000;
    rx_cnt = 0;
  end
  // Bit clock runs only during transfers and rests between them
  always #62.5 if (run) sck = ~sck;
  // Released data line shows the inverse so a stale bit is never mistaken for data
  always @(negedge run) sd_to_unit = ~sd_to_unit;
  // Two 16-slot channels, data one slot behind word select, MSB first
  always @(negedge sck) begin
    slot <= slot + 5'h01;
    ws_slv <= (slot + 5'h01) >= 5'h10;
    sd_to_unit <= tx_word[5'h1F - slot];
  end
  // At each left-channel start the last 32 bits form the previous frame
  always @(posedge sck) begin
    sr <= {sr[30:0], sd_from_unit};
    ws_prev <= ws_mst;
    if (ws_prev && !ws_mst) begin
      rx_word <= {sr[30:0], sd_from_unit};
      rx_cnt <= rx_cnt + 1;
    end
  end
endmodule

// ==== bench/audio_serial_fifo_port_unit_bench.sv ====
// Self-checking bench for the audio serial unit
`timescale 1ns/100ps
module audio_serial_fifo_port_unit_bench;
  typedef struct packed {logic [5:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic        clk, rst_b, wr_stb, rd_stb, target_ready_r, int_rd_r, int_wr_r;
  logic        run, sck_in, ws_slv, sd_to_unit;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata_r, tx_word, rx_word, got;
  logic [3:0]  ws_in, ws_out_r, ws_oe_b_r, serial_data_input, serial_data_output_r, sd_oe_b_r;
  int          rx_cnt, fail_count, checks_done, cyc, nrd, nwr, i, k;
  // Register table: address, written word, expected read-back
  row_t rows [7] = '{
    '{6'h24, 32'hFFFF_3210, 32'h0000_3210},
    '{6'h28, 32'h0000_0011, 32'h0000_0011},
    '{6'h18, 32'hFFFF_F2FF, 32'h0000_0200},
    '{6'h14, 32'hFFFF_FFFF, 32'h0000_0000},
    '{6'h34, 32'hFFFF_FFFF, 32'h0000_0000},
    '{6'h20, 32'hFFFF_FFFF, 32'h0000_0000},
    '{6'h00, 32'h2AAA_AAAA, 32'h2AAA_AAAA}};
  // Pin levels: port 0 word select and data loop back only when the unit drives them
  assign ws_in = {ws_slv, ws_slv, ws_slv, ws_oe_b_r[0] ? ws_slv : ws_out_r[0]};
  assign serial_data_input = {{3{sd_to_unit}}, sd_oe_b_r[0] ? sd_to_unit : serial_data_output_r[0]};
  audio_serial_fifo_port_unit dut (.clk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb, .rdata_r,
    .target_ready_r, .sck_in, .ws_in, .ws_out_r, .ws_oe_b_r, .serial_data_input,
    .serial_data_output_r, .sd_oe_b_r, .int_rd_r, .int_wr_r);
  audio_serial_peer peer (.run, .tx_word, .sck(sck_in), .ws_slv, .sd_to_unit,
    .ws_mst(ws_out_r[0]), .sd_from_unit(serial_data_output_r[0]), .rx_word, .rx_cnt);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Cycle ceiling and read and write interrupt tallies
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (int_rd_r === 1'b1) nrd <= nrd + 1;
    if (int_wr_r === 1'b1) nwr <= nwr + 1;
    if (cyc == 40000) begin
      fail_count = fail_count + 1;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rdata_r;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    {rst_b, wr_stb, rd_stb, run, addr, wdata} = '0;
    {fail_count, checks_done, cyc, nrd, nwr} = '0;
    tx_word = 32'hA5C3_1E87;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(6'h00, got);
    chk("enable after reset", 32'h0, {31'h0, got[0]});
    for (i = 0; i < 7; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, got);
      chk($sformatf("reg %h", rows[i].a), rows[i].e, got);
    end
    // Port 0 master output from the bus, port 1 slave input to the bus
    wr(6'h24, 32'h0000_0200);
    wr(6'h28, 32'h0000_0011);
    wr(6'h18, 32'h0000_0200);
    wr(6'h00, 32'h0C20_0101);
    wr(6'h04, 32'h8001_7FFE);
    repeat (3) @(posedge clk);
    rd(6'h24, got);
    chk("part0 pointers", 32'h0101_0200, got);
    rd(6'h20, got);
    chk("port status", 32'h0000_000C, got);
    run = 1'b1;
    k = 0;
    for (i = 0; i < 12 && k == 0; i++) begin
      @(rx_cnt);
      #1 k = (rx_word === 32'h8001_7FFE);
    end
    chk("word sent", 32'h1, k);
    @(rx_cnt);
    #1 chk("empty frame", 32'h0, rx_word);
    repeat (2) @(rx_cnt);
    for (i = 0; i < 3; i++) rd(6'h08, got);
    chk("input word", 32'hA5C3_1E87, got);
    chk("read interrupt", 32'h1, {31'h0, nrd > 0});
    rd(6'h18, got);
    chk("identify port 1", 32'h1, {31'h0, got[1]});
    // Port 0 fills two words past its holding register; draining one drops the threshold
    wr(6'h18, 32'h0000_0300);
    @(rx_cnt);
    repeat (20) @(posedge clk);
    for (i = 0; i < 3; i++) wr(6'h04, 32'h1234_5678);
    repeat (2) @(rx_cnt);
    #1 chk("word repeated", 32'h1234_5678, rx_word);
    chk("write interrupt", 32'h1, {31'h0, nwr > 0});
    wr(6'h00, 32'h0000_0000);
    rd(6'h24, got);
    chk("pointers cleared", 32'h0000_0200, got);
    run = 1'b0;
    finish_test();
  end
endmodule
